// [design/lmirx_pkg.sv]
/*
 * Shared constants for the literal / move / indirect / return executor:
 * register offsets, reset values, opcode patterns and state encodings.
 * Assumes 14-bit instruction words and a 32-bit AHB-Lite register bus.
 */
package lmirx_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses, haddr[11:0])
	// ----------------------------------------------------------------
	localparam logic [11:0] LMIRX_OFS_ACC = 12'h000;
	localparam logic [11:0] LMIRX_OFS_BANK = 12'h004;
	localparam logic [11:0] LMIRX_OFS_PAGE_LATCH = 12'h008;
	localparam logic [11:0] LMIRX_OFS_PRESC = 12'h00C;
	localparam logic [11:0] LMIRX_OFS_PTR0 = 12'h010;
	localparam logic [11:0] LMIRX_OFS_PTR1 = 12'h014;
	localparam logic [11:0] LMIRX_OFS_PC = 12'h018;
	localparam logic [11:0] LMIRX_OFS_INTCTL = 12'h01C;
	localparam logic [11:0] LMIRX_OFS_PWRCTL = 12'h020;
	localparam logic [11:0] LMIRX_OFS_STATUS = 12'h024;
	// Data memory read window: haddr[11:10] == 01, index haddr[9:2]
	localparam logic [1:0] LMIRX_MEM_WIN = 2'h1;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int LMIRX_INT_EN_BIT = 7;
	localparam int LMIRX_RIF_BIT = 2;
	localparam logic [7:0] LMIRX_ACC_RST = 8'h00;
	localparam logic [4:0] LMIRX_BANK_RST = 5'h00;
	localparam logic [6:0] LMIRX_PAGE_LATCH_RST = 7'h00;
	localparam logic [7:0] LMIRX_PRESC_RST = 8'hFF;
	localparam logic [15:0] LMIRX_PTR_RST = 16'h0000;
	localparam logic [14:0] LMIRX_PC_RST = 15'h0000;
	localparam logic [7:0] LMIRX_INTCTL_RST = 8'h00;
	localparam logic [7:0] LMIRX_STATUS_RST = 8'h00;
	localparam logic [6:0] LMIRX_PORT1_ADDR = 7'h01;
	localparam int LMIRX_RET_CYCLES = 2;
	// ----------------------------------------------------------------
	// Opcode patterns (word & mask == value)
	// ----------------------------------------------------------------
	localparam logic [13:0] LMIRX_M_BANK = 14'h3FE0;
	localparam logic [13:0] LMIRX_V_BANK = 14'h0020;
	localparam logic [13:0] LMIRX_M_PAGE = 14'h3F80;
	localparam logic [13:0] LMIRX_V_PAGE = 14'h3180;
	localparam logic [13:0] LMIRX_M_LIT = 14'h3F00;
	localparam logic [13:0] LMIRX_V_LIT = 14'h3000;
	localparam logic [13:0] LMIRX_M_FILE = 14'h3F80;
	localparam logic [13:0] LMIRX_V_FILE = 14'h0080;
	localparam logic [13:0] LMIRX_M_INDMM = 14'h3FF8;
	localparam logic [13:0] LMIRX_V_INDMM = 14'h0018;
	localparam logic [13:0] LMIRX_M_INDK = 14'h3F80;
	localparam logic [13:0] LMIRX_V_INDK = 14'h3F80;
	localparam logic [13:0] LMIRX_V_NOP = 14'h0000;
	localparam logic [13:0] LMIRX_V_OPT = 14'h0062;
	localparam logic [13:0] LMIRX_V_RST = 14'h0001;
	localparam logic [13:0] LMIRX_V_RET = 14'h0009;
	// Pointer update codes
	localparam logic [1:0] LMIRX_UPD_PREINC = 2'b00;
	localparam logic [1:0] LMIRX_UPD_PREDEC = 2'b01;
	localparam logic [1:0] LMIRX_UPD_POSTINC = 2'b10;
	localparam logic [1:0] LMIRX_UPD_POSTDEC = 2'b11;
	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		LMIRX_OP_NOP = 4'b0000,
		LMIRX_OP_BANK = 4'b0001,
		LMIRX_OP_PAGE = 4'b0010,
		LMIRX_OP_LIT = 4'b0011,
		LMIRX_OP_FILE = 4'b0100,
		LMIRX_OP_INDMM = 4'b0101,
		LMIRX_OP_INDK = 4'b0110,
		LMIRX_OP_OPT = 4'b0111,
		LMIRX_OP_RST = 4'b1000,
		LMIRX_OP_RET = 4'b1001,
		LMIRX_OP_OTHER = 4'b1010
	} lmirx_op_type;
	typedef enum logic [0:0] {
		LMIRX_ST_RUN = 1'b0,
		LMIRX_ST_RET = 1'b1
	} lmirx_st_type;
endpackage : lmirx_pkg

// [design/lmirx_mem_if.sv]
/*
 * Data memory port bundle between the executor and its memory.
 * Assumes a single clock shared by both ends.
 */
interface lmirx_mem_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : lmirx_mem_if

// [design/lmirx_mem.sv]
/*
 * 256-byte data memory, one write port, one registered read port.
 * Assumes the executor drives the ctrl modport; contents are not reset.
 */
module lmirx_mem (
	input wire logic clk,
	lmirx_mem_if.mem m
);
	logic [7:0] ram [256];
	logic [7:0] rd_data_r;

	// Read data come from a register, one cycle after the address
	always_ff @(posedge clk)
	begin
		if (m.wr_en)
		begin
			ram[m.wr_addr] <= m.wr_data;
		end
		rd_data_r <= ram[m.rd_addr];
	end

	assign m.rd_data = rd_data_r;
endmodule : lmirx_mem

// [design/lmirx_core.sv]
/*
 * Executor for literal loads, accumulator stores, indirect stores,
 * no-op, software reset and return-from-interrupt, with an AHB-Lite
 * register slave and the data memory instance.
 * Assumes instruction words are offered by program memory with a
 * valid/ready handshake and that the stack supplies its top entry.
 */
// Chosen here: register access over AHB-Lite and the register offsets.
module lmirx_core (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [13:0] instr_data,
	input wire logic instr_valid,
	output logic instr_ready,
	output logic [14:0] fetch_addr,
	input wire logic [14:0] top_of_stack,
	output logic stack_pop,
	output logic soft_reset,
	output logic global_interrupt_enable,
	output logic [7:0] presc_cfg,
	output logic [4:0] bank_select_register,
	output logic [6:0] program_counter_latch_high
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		lmirx_pkg::lmirx_st_type st;
		logic [7:0] acc;
		logic [4:0] bank;
		logic [6:0] page_latch;
		logic [7:0] presc;
		logic [1:0][15:0] ptr;
		logic [14:0] pc;
		logic [7:0] intctl;
		logic reset_instruction_flag_n;
		logic [7:0] status;
		logic dp_act;
		logic dp_wr;
		logic [11:0] dp_addr;
		logic rd_wait;
		logic [31:0] hrdata;
		logic pop;
		logic srst;
	} lmirx_state_type;

	lmirx_state_type s_r;
	lmirx_state_type s_nxt;
	lmirx_pkg::lmirx_op_type cur_op;
	logic take;
	lmirx_mem_if mif ();

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Constant state after reset; the reset-instruction flag starts high
	function automatic lmirx_state_type lmirx_rst_state();
		lmirx_state_type r;
		r = '0;
		r.st = lmirx_pkg::LMIRX_ST_RUN;
		r.acc = lmirx_pkg::LMIRX_ACC_RST;
		r.bank = lmirx_pkg::LMIRX_BANK_RST;
		r.page_latch = lmirx_pkg::LMIRX_PAGE_LATCH_RST;
		r.presc = lmirx_pkg::LMIRX_PRESC_RST;
		r.ptr[0] = lmirx_pkg::LMIRX_PTR_RST;
		r.ptr[1] = lmirx_pkg::LMIRX_PTR_RST;
		r.pc = lmirx_pkg::LMIRX_PC_RST;
		r.intctl = lmirx_pkg::LMIRX_INTCTL_RST;
		r.reset_instruction_flag_n = 1'b1;
		r.status = lmirx_pkg::LMIRX_STATUS_RST;
		return r;
	endfunction : lmirx_rst_state

	// Instruction word to operation class
	function automatic lmirx_pkg::lmirx_op_type lmirx_decode(input logic [13:0] w);
		lmirx_pkg::lmirx_op_type op;
		op = lmirx_pkg::LMIRX_OP_OTHER;
		if (w == lmirx_pkg::LMIRX_V_NOP)
			op = lmirx_pkg::LMIRX_OP_NOP;
		else if (w == lmirx_pkg::LMIRX_V_OPT)
			op = lmirx_pkg::LMIRX_OP_OPT;
		else if (w == lmirx_pkg::LMIRX_V_RST)
			op = lmirx_pkg::LMIRX_OP_RST;
		else if (w == lmirx_pkg::LMIRX_V_RET)
			op = lmirx_pkg::LMIRX_OP_RET;
		else if ((w & lmirx_pkg::LMIRX_M_INDMM) == lmirx_pkg::LMIRX_V_INDMM)
			op = lmirx_pkg::LMIRX_OP_INDMM;
		else if ((w & lmirx_pkg::LMIRX_M_BANK) == lmirx_pkg::LMIRX_V_BANK)
			op = lmirx_pkg::LMIRX_OP_BANK;
		else if ((w & lmirx_pkg::LMIRX_M_FILE) == lmirx_pkg::LMIRX_V_FILE)
			op = lmirx_pkg::LMIRX_OP_FILE;
		else if ((w & lmirx_pkg::LMIRX_M_INDK) == lmirx_pkg::LMIRX_V_INDK)
			op = lmirx_pkg::LMIRX_OP_INDK;
		else if ((w & lmirx_pkg::LMIRX_M_PAGE) == lmirx_pkg::LMIRX_V_PAGE)
			op = lmirx_pkg::LMIRX_OP_PAGE;
		else if ((w & lmirx_pkg::LMIRX_M_LIT) == lmirx_pkg::LMIRX_V_LIT)
			op = lmirx_pkg::LMIRX_OP_LIT;
		return op;
	endfunction : lmirx_decode

	// Pointer step by one; 16-bit arithmetic wraps at both ends
	function automatic logic [15:0] lmirx_step(input logic [15:0] p, input logic dec);
		return dec ? 16'(p - 16'h0001) : 16'(p + 16'h0001);
	endfunction : lmirx_step

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	assign cur_op = lmirx_decode(instr_data);
	assign instr_ready = (s_r.st == lmirx_pkg::LMIRX_ST_RUN);
	assign take = instr_valid && instr_ready;

	// Bus slave first, core after it, so a core update wins a same-cycle write
	always_comb
	begin
		logic n;
		logic [15:0] ea;
		logic [15:0] p;
		s_nxt = s_r;
		n = 1'b0;
		ea = 16'h0000;
		p = 16'h0000;
		s_nxt.pop = 1'b0;
		s_nxt.srst = 1'b0;
		mif.wr_en = 1'b0;
		mif.wr_addr = 8'h00;
		mif.wr_data = s_r.acc;
		mif.rd_addr = haddr[9:2];
		// Data phase of a bus transfer
		if (s_r.dp_act && s_r.dp_wr)
		begin
			unique case (s_r.dp_addr)
				lmirx_pkg::LMIRX_OFS_ACC: s_nxt.acc = hwdata[7:0];
				lmirx_pkg::LMIRX_OFS_BANK: s_nxt.bank = hwdata[4:0];
				lmirx_pkg::LMIRX_OFS_PAGE_LATCH: s_nxt.page_latch = hwdata[6:0];
				lmirx_pkg::LMIRX_OFS_PRESC: s_nxt.presc = hwdata[7:0];
				lmirx_pkg::LMIRX_OFS_PTR0: s_nxt.ptr[0] = hwdata[15:0];
				lmirx_pkg::LMIRX_OFS_PTR1: s_nxt.ptr[1] = hwdata[15:0];
				lmirx_pkg::LMIRX_OFS_INTCTL: s_nxt.intctl = hwdata[7:0];
				lmirx_pkg::LMIRX_OFS_PWRCTL: s_nxt.reset_instruction_flag_n = hwdata[lmirx_pkg::LMIRX_RIF_BIT];
				lmirx_pkg::LMIRX_OFS_STATUS: s_nxt.status = hwdata[7:0];
				default: ;
			endcase
		end
		else if (s_r.dp_act && s_r.rd_wait)
		begin
			// One wait state: the read value is captured here, shown next cycle
			s_nxt.rd_wait = 1'b0;
			s_nxt.hrdata = 32'h0000_0000;
			if (s_r.dp_addr[11:10] == lmirx_pkg::LMIRX_MEM_WIN)
				s_nxt.hrdata = {24'h000000, mif.rd_data};
			else
			begin
				unique case (s_r.dp_addr)
					lmirx_pkg::LMIRX_OFS_ACC: s_nxt.hrdata = {24'h000000, s_r.acc};
					lmirx_pkg::LMIRX_OFS_BANK: s_nxt.hrdata = {27'h0000000, s_r.bank};
					lmirx_pkg::LMIRX_OFS_PAGE_LATCH: s_nxt.hrdata = {25'h0000000, s_r.page_latch};
					lmirx_pkg::LMIRX_OFS_PRESC: s_nxt.hrdata = {24'h000000, s_r.presc};
					lmirx_pkg::LMIRX_OFS_PTR0: s_nxt.hrdata = {16'h0000, s_r.ptr[0]};
					lmirx_pkg::LMIRX_OFS_PTR1: s_nxt.hrdata = {16'h0000, s_r.ptr[1]};
					lmirx_pkg::LMIRX_OFS_PC: s_nxt.hrdata = {17'h00000, s_r.pc};
					lmirx_pkg::LMIRX_OFS_INTCTL: s_nxt.hrdata = {24'h000000, s_r.intctl};
					lmirx_pkg::LMIRX_OFS_PWRCTL: s_nxt.hrdata = {29'h00000000, s_r.reset_instruction_flag_n, 2'b00};
					lmirx_pkg::LMIRX_OFS_STATUS: s_nxt.hrdata = {24'h000000, s_r.status};
					default: ;
				endcase
			end
		end
		// Address phase; a wait state holds hready low so nothing new lands
		if (hready)
		begin
			s_nxt.dp_act = hsel && htrans[1];
			s_nxt.dp_wr = hwrite;
			s_nxt.dp_addr = haddr[11:0];
			s_nxt.rd_wait = hsel && htrans[1] && !hwrite;
		end
		// Instruction execution
		if (s_r.st == lmirx_pkg::LMIRX_ST_RET)
		begin
			// Second cycle of the return: a bubble, no fetch taken
			s_nxt.st = lmirx_pkg::LMIRX_ST_RUN;
		end
		else if (take)
		begin
			s_nxt.pc = 15'(s_r.pc + 15'h0001);
			unique case (cur_op)
				lmirx_pkg::LMIRX_OP_BANK: s_nxt.bank = instr_data[4:0];
				lmirx_pkg::LMIRX_OP_PAGE: s_nxt.page_latch = instr_data[6:0];
				lmirx_pkg::LMIRX_OP_LIT: s_nxt.acc = instr_data[7:0];
				lmirx_pkg::LMIRX_OP_OPT: s_nxt.presc = s_r.acc;
				lmirx_pkg::LMIRX_OP_FILE:
				begin
					// Port addresses hold nothing; they go through their pointer
					mif.wr_en = 1'b1;
					if (instr_data[6:1] == 6'h00)
						mif.wr_addr = s_r.ptr[instr_data[0]][7:0];
					else
						mif.wr_addr = {s_r.bank[0], instr_data[6:0]};
				end
				lmirx_pkg::LMIRX_OP_INDMM:
				begin
					n = instr_data[2];
					p = lmirx_step(s_r.ptr[n], instr_data[0]);
					// Pre forms use the stepped value, post forms the old one
					ea = instr_data[1] ? s_r.ptr[n] : p;
					s_nxt.ptr[n] = p;
					mif.wr_en = 1'b1;
					mif.wr_addr = ea[7:0];
				end
				lmirx_pkg::LMIRX_OP_INDK:
				begin
					n = instr_data[6];
					ea = 16'(s_r.ptr[n] + {{10{instr_data[5]}}, instr_data[5:0]});
					mif.wr_en = 1'b1;
					mif.wr_addr = ea[7:0];
				end
				lmirx_pkg::LMIRX_OP_RST:
				begin
					// Memory keeps its contents; everything else restarts, except that the reset-instruction flag clears and soft_reset pulses
					s_nxt = lmirx_rst_state();
					s_nxt.reset_instruction_flag_n = 1'b0;
					s_nxt.srst = 1'b1;
				end
				lmirx_pkg::LMIRX_OP_RET:
				begin
					s_nxt.pc = top_of_stack;
					s_nxt.pop = 1'b1;
					s_nxt.intctl[lmirx_pkg::LMIRX_INT_EN_BIT] = 1'b1;
					s_nxt.st = lmirx_pkg::LMIRX_ST_RET;
				end
				// No-op and unsupported words only advance the counter
				lmirx_pkg::LMIRX_OP_NOP, lmirx_pkg::LMIRX_OP_OTHER: ;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_r <= lmirx_rst_state();
		else
			s_r <= s_nxt;
	end

	// ----------------------------------------------------------------
	// Memory and outputs
	// ----------------------------------------------------------------
	lmirx_mem u_mem (
		.clk(clk),
		.m(mif.mem)
	);

	// Writes never wait; reads take one wait state, none when a software reset is taken in their address phase
	assign hreadyout = !(s_r.dp_act && s_r.rd_wait);
	assign hresp = 1'b0;
	assign hrdata = s_r.hrdata;
	assign fetch_addr = s_r.pc;
	assign stack_pop = s_r.pop;
	assign soft_reset = s_r.srst;
	assign global_interrupt_enable = s_r.intctl[lmirx_pkg::LMIRX_INT_EN_BIT];
	assign presc_cfg = s_r.presc;
	assign bank_select_register = s_r.bank;
	assign program_counter_latch_high = s_r.page_latch;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_bank_load;
		take && cur_op == lmirx_pkg::LMIRX_OP_BANK |=> s_r.bank == $past(instr_data[4:0]);
	endproperty
	a_bank_load: assert property (p_bank_load) else $error("bank literal not loaded");
	property p_page_load;
		take && cur_op == lmirx_pkg::LMIRX_OP_PAGE |=> s_r.page_latch == $past(instr_data[6:0]);
	endproperty
	a_page_load: assert property (p_page_load) else $error("page literal not loaded");
	property p_lit_load;
		take && cur_op == lmirx_pkg::LMIRX_OP_LIT |=> s_r.acc == $past(instr_data[7:0]) && instr_ready;
	endproperty
	a_lit_load: assert property (p_lit_load) else $error("accumulator literal not loaded");
	property p_file_store;
		take && cur_op == lmirx_pkg::LMIRX_OP_FILE && instr_data[6:1] != 6'h00
			|-> mif.wr_en && mif.wr_data == s_r.acc && mif.wr_addr[6:0] == instr_data[6:0];
	endproperty
	a_file_store: assert property (p_file_store) else $error("file store wrong");
	property p_port_redirect;
		take && cur_op == lmirx_pkg::LMIRX_OP_FILE && instr_data[6:0] == lmirx_pkg::LMIRX_PORT1_ADDR
			|-> mif.wr_addr == s_r.ptr[1][7:0];
	endproperty
	a_port_redirect: assert property (p_port_redirect) else $error("port not redirected");
	property p_preinc;
		take && cur_op == lmirx_pkg::LMIRX_OP_INDMM && instr_data[1:0] == lmirx_pkg::LMIRX_UPD_PREINC
			&& !instr_data[2] |-> mif.wr_addr == 8'(s_r.ptr[0][7:0] + 8'h01)
			##1 s_r.ptr[0] == 16'($past(s_r.ptr[0]) + 16'h0001);
	endproperty
	a_preinc: assert property (p_preinc) else $error("preincrement wrong");
	property p_postdec;
		take && cur_op == lmirx_pkg::LMIRX_OP_INDMM && instr_data[1:0] == lmirx_pkg::LMIRX_UPD_POSTDEC
			&& instr_data[2] |-> mif.wr_addr == s_r.ptr[1][7:0]
			##1 s_r.ptr[1] == 16'($past(s_r.ptr[1]) - 16'h0001);
	endproperty
	a_postdec: assert property (p_postdec) else $error("postdecrement wrong");

	property p_rel_keep;
		take && cur_op == lmirx_pkg::LMIRX_OP_INDK && !instr_data[6] |=> $stable(s_r.ptr[0]);
	endproperty
	a_rel_keep: assert property (p_rel_keep) else $error("relative form moved pointer");

	property p_status_kept;
		!(s_r.dp_act && s_r.dp_wr && s_r.dp_addr == lmirx_pkg::LMIRX_OFS_STATUS) && s_nxt.srst == 1'b0
			|=> $stable(s_r.status);
	endproperty
	a_status_kept: assert property (p_status_kept) else $error("status changed");

	property p_presc_load;
		take && cur_op == lmirx_pkg::LMIRX_OP_OPT |=> s_r.presc == $past(s_r.acc);
	endproperty
	a_presc_load: assert property (p_presc_load) else $error("prescaler not loaded");

	property p_soft_reset;
		take && cur_op == lmirx_pkg::LMIRX_OP_RST |=> soft_reset && !s_r.reset_instruction_flag_n
			&& s_r.pc == lmirx_pkg::LMIRX_PC_RST;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("software reset wrong");

	property p_return;
		take && cur_op == lmirx_pkg::LMIRX_OP_RET |=> stack_pop && !instr_ready
			&& fetch_addr == $past(top_of_stack) && global_interrupt_enable ##1 instr_ready;
	endproperty
	a_return: assert property (p_return) else $error("return sequence wrong");

	property p_nop_step;
		take && cur_op == lmirx_pkg::LMIRX_OP_NOP |-> !mif.wr_en ##1 fetch_addr == 15'($past(fetch_addr) + 15'h0001);
	endproperty
	a_nop_step: assert property (p_nop_step) else $error("no-op wrong");

	c_return: cover property (take && cur_op == lmirx_pkg::LMIRX_OP_RET ##2 take);
	c_indirect: cover property (take && cur_op == lmirx_pkg::LMIRX_OP_INDMM ##1 take && cur_op == lmirx_pkg::LMIRX_OP_INDK);
	c_bus_read: cover property (s_r.dp_act && !s_r.dp_wr && hreadyout);
	c_soft_reset: cover property (soft_reset);
endmodule : lmirx_core

// [tb/lmirx_prog_model.sv]
/*
 * Program memory model: hands queued instruction words to the core over
 * the valid/ready port and presents a top-of-stack value.
 * Assumes the bench pushes words into q, sets stack_top_r and drives stall.
 */
module lmirx_prog_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic stall,
	input wire logic instr_ready,
	output logic [13:0] instr_data,
	output logic instr_valid,
	output logic [14:0] top_of_stack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] q[$];
	logic [14:0] stack_top_r = 15'h0000;
	assign top_of_stack = stack_top_r;
	// An offered word holds until taken; idle data flips so a stale word never looks fresh
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			instr_valid <= 1'b0;
			instr_data <= 14'h0000;
		end
		else if (!instr_valid || instr_ready)
		begin
			if (instr_valid)
				void'(q.pop_front());
			instr_valid <= (q.size() != 0) && !stall;
			instr_data <= ((q.size() != 0) && !stall) ? q[0] : ~instr_data;
		end
	end
endmodule : lmirx_prog_model

// [tb/tb.sv]
/*
 * Self-checking bench for lmirx_core: a table of instruction rows, then
 * hand tests for return, software reset and an unmapped register.
 * Assumes the core is the only AHB-Lite slave, so hreadyout is hready.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [13:0] w; logic [11:0] a; logic [31:0] e;} lmirx_row_type;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, stall = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, instr_valid, instr_ready, stack_pop, soft_reset, int_en;
	logic [13:0] instr_data;
	logic [14:0] fetch_addr, top_of_stack;
	logic [7:0] presc_cfg;
	logic [4:0] bank;
	logic [6:0] page_latch;
	int n_mismatch = 0, checks_done = 0, pops, busy;
	// Word, register offset read back, expected value; a 0000 word is a no-op
	lmirx_row_type rows [22] = '{
		'{14'h305A, 12'h000, 32'h5A}, '{14'h31FF, 12'h008, 32'h7F},
		'{14'h002E, 12'h004, 32'h0E}, '{14'h0062, 12'h00C, 32'h5A},
		'{14'h00A3, 12'h48C, 32'h5A}, '{14'h30C3, 12'h000, 32'hC3},
		'{14'h0018, 12'h504, 32'hC3}, '{14'h0000, 12'h010, 32'h41},
		'{14'h001E, 12'h7FC, 32'hC3}, '{14'h0000, 12'h014, 32'h0000},
		'{14'h303C, 12'h000, 32'h3C}, '{14'h001D, 12'h7FC, 32'h3C},
		'{14'h0000, 12'h014, 32'hFFFF}, '{14'h001B, 12'h504, 32'h3C},
		'{14'h0000, 12'h010, 32'h40}, '{14'h3FA0, 12'h480, 32'h3C},
		'{14'h0000, 12'h010, 32'h40}, '{14'h3FDF, 12'h478, 32'h3C},
		'{14'h0080, 12'h500, 32'h3C}, '{14'h0000, 12'h024, 32'hA5},
		'{14'h3077, 12'h000, 32'h77}, '{14'h0081, 12'h7FC, 32'h77}
	};
	always #12.5 clk = ~clk;
	lmirx_core i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .instr_data(instr_data), .instr_valid(instr_valid),
		.instr_ready(instr_ready), .fetch_addr(fetch_addr), .top_of_stack(top_of_stack), .stack_pop(stack_pop),
		.soft_reset(soft_reset), .global_interrupt_enable(int_en), .presc_cfg(presc_cfg),
		.bank_select_register(bank), .program_counter_latch_high(page_latch));
	lmirx_prog_model i_prog (.clk(clk), .sys_rst(sys_rst), .stall(stall), .instr_ready(instr_ready),
		.instr_data(instr_data), .instr_valid(instr_valid), .top_of_stack(top_of_stack));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task tally_and_finish;
		$display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// Bounded wait; a hang counts as a mismatch and ends the run
	task guard(input int k);
		if (k == 50)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	endtask : guard
	// Hold the phase until hready is seen high, then return just after that edge
	task wait_rdy;
		int k;
		@(negedge clk);
		for (k = 0; hreadyout !== 1'b1; k++)
		begin
			guard(k);
			@(negedge clk);
		end
		rd = hrdata;
		@(posedge clk);
	endtask : wait_rdy
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy;
	endtask : bus
	task rdc(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask : rdc
	task exec(input logic [13:0] w);
		int k;
		i_prog.q.push_back(w);
		@(negedge clk);
		for (k = 0; i_prog.q.size() != 0; k++)
		begin
			guard(k);
			@(negedge clk);
		end
		@(posedge clk);
	endtask : exec
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		cmp(32'(presc_cfg), 32'hFF);
		cmp(32'(fetch_addr), 32'h0);
		@(posedge clk);
		bus(1'b1, 12'h024, 32'hA5);
		bus(1'b1, 12'h010, 32'h40);
		bus(1'b1, 12'h014, 32'hFFFF);
		foreach (rows[i])
		begin
			exec(rows[i].w);
			cmp(32'(fetch_addr), 32'(i + 1));
			rdc(rows[i].a, rows[i].e);
		end
		cmp(32'(bank), 32'h0E);
		cmp(32'(page_latch), 32'h7F);
		cmp(32'(presc_cfg), 32'h5A);
		$display("Test table done");
		// Return held back by a slow memory, then a no-op right behind it
		// Stall is seen by the model before the words are queued, so the return cannot slip out early
		i_prog.stack_top_r <= 15'h1234;
		stall <= 1'b1;
		@(posedge clk);
		i_prog.q.push_back(14'h0009);
		i_prog.q.push_back(14'h0000);
		repeat (3) @(posedge clk);
		stall <= 1'b0;
		pops = 0;
		busy = 0;
		repeat (8)
		begin
			@(negedge clk);
			pops += int'(stack_pop);
			busy += int'(!instr_ready);
		end
		cmp(32'(pops), 32'h1);
		cmp(32'(busy), 32'h1);
		cmp(32'(fetch_addr), 32'h1235);
		cmp(32'(int_en), 32'h1);
		@(posedge clk);
		rdc(12'h01C, 32'h80);
		$display("Test return done");
		// Software reset clears the flag set by the bus and the core registers
		bus(1'b1, 12'h020, 32'h4);
		rdc(12'h020, 32'h4);
		i_prog.q.push_back(14'h0001);
		pops = 0;
		repeat (6)
		begin
			@(negedge clk);
			pops += int'(soft_reset);
		end
		cmp(32'(pops), 32'h1);
		cmp(32'(bank), 32'h0);
		cmp(32'(int_en), 32'h0);
		cmp(32'(presc_cfg), 32'hFF);
		cmp(32'(page_latch), 32'h0);
		cmp(32'(fetch_addr), 32'h0);
		@(posedge clk);
		rdc(12'h020, 32'h0);
		rdc(12'h000, 32'h0);
		// Unmapped offset reads zero
		rdc(12'h030, 32'h0);
		cmp(32'(hresp), 32'h0);
		$display("Test reset done");
		tally_and_finish;
	end
endmodule : tb
